//--- rtl/safc_pkg.sv
package safc_pkg;
    // ==========================================================
    // Frame geometry
    localparam int RESULT_BITS     = 14;
    localparam int FRAME_CLOCKS    = 16;
    localparam int SAMPLE_EDGE     = 9;
    // ==========================================================
    // Timing figures in ns, and the core clock period
    localparam int CLK_PERIOD_NS   = 4;
    localparam int CONV_MAX_NS     = 365;
    localparam int BUSY_DELAY_NS   = 40;
    localparam int ABORT_GUARD_NS  = 10;
    localparam int ABORT_DELAY_NS  = 5;
    localparam int RST_MIN_NS      = 45;
    localparam int RST_MAX_NS      = 6140;
    localparam int PWD_MIN_NS      = 7200;
    localparam int LINK_HALF_NS    = 10;
    localparam int CS_SETUP_NS     = 8;
    localparam int CS_HOLD_NS      = 10;
    // ==========================================================
    // Cycle counts: least times round up, longest times round down
    localparam int CONV_CYC     = CONV_MAX_NS / CLK_PERIOD_NS;
    localparam int RST_MIN_CYC  = (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RST_MAX_CYC  = RST_MAX_NS / CLK_PERIOD_NS;
    localparam int PWD_MIN_CYC  = (PWD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GUARD_CYC    = (ABORT_GUARD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HALF_CYC     = (LINK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETUP_CYC    = (CS_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOLD_CYC     = (CS_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // ==========================================================
    // Framing modes
    typedef enum logic {
        SAFC_MODE_SPI = 1'b0,
        SAFC_MODE_DSP = 1'b1
    } safc_mode_t;
endpackage

//--- rtl/safc_link_if.sv
`timescale 1ns/1ns
// ==========================================================
// Serial link between converter and its host
interface safc_link_if;
    logic serial_clk;
    logic chip_select_n;
    logic frame_sync;
    logic powerdown_reset_n;
    logic busy;
    logic serial_result_out;
    logic serial_result_oe;
    // Resolved data wire seen by the host; released line reads high
    logic serial_result_line;
    assign serial_result_line = serial_result_oe ? serial_result_out : 1'b1;

    modport device (
        input  serial_clk,
        input  chip_select_n,
        input  frame_sync,
        input  powerdown_reset_n,
        output busy,
        output serial_result_out,
        output serial_result_oe
    );
    modport host (
        output serial_clk,
        output chip_select_n,
        output frame_sync,
        output powerdown_reset_n,
        input  busy,
        input  serial_result_line
    );
endinterface // safc_link_if

//--- rtl/safc_device.sv
`timescale 1ns/1ns
// Behaviour
// - busy high at most 365 ns
// - host keeps clock phases at least 10 ns
// - busy rises within 40 ns of 16th fall
// - DSP: early frame sync aborts conversion
// - SPI: early chip select fall aborts conversion
// - DSP: frame sync after 9th rise restarts
// - SPI: chip select rise after 9th aborts
// - chip select held 10 ns after 16th fall
// - data output released when chip select high
// - short reset pulse resets, no power-down
// - long reset pulse enters power-down
// - host waits 25 ms after power-up; here the host goes back to idle at once and may start a frame
// - data released on reset pin falling
// - DSP: MSB valid after frame sync rise
// - SPI: MSB valid after chip select fall
// - later bits valid after rising clock
// - DSP: chip select low before frame sync
// - SPI: chip select pulse at least 15 ns
// - 16 clocks, sample 9th rise, convert 16th fall
// - MSB first, bits change on rising edges
// - DSP: frame sync rise starts frame
module safc_device (
    input  wire logic                         core_clk,
    input  wire logic                         rst_n,
    safc_link_if.device                       link,
    input  wire safc_pkg::safc_mode_t         mode,
    input  wire logic [safc_pkg::RESULT_BITS-1:0] sample_value,
    output logic                              sample_taken,
    output logic [safc_pkg::RESULT_BITS-1:0]  result_q,
    output logic                              result_valid,
    output logic                              device_reset_pulse,
    output logic                              powered_down_q
);
    localparam int RB = safc_pkg::RESULT_BITS;

    // ==========================================================
    // Synchronisers for every link input
    logic [1:0] sclk_s, csn_s, fs_s, pwr_s;
    logic       sclk_d1, csn_d1, fs_d1, pwr_d1;
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            sclk_s <= 2'h3; // Link clock idles high: no false edge after reset
            csn_s  <= 2'h3;
            fs_s   <= 2'h0;
            pwr_s  <= 2'h3;
            sclk_d1 <= 1'b1;
            csn_d1 <= 1'b1;
            fs_d1  <= 1'b0;
            pwr_d1 <= 1'b1;
        end else begin
            sclk_s <= {sclk_s[0], link.serial_clk};
            csn_s  <= {csn_s[0], link.chip_select_n};
            fs_s   <= {fs_s[0], link.frame_sync};
            pwr_s  <= {pwr_s[0], link.powerdown_reset_n};
            sclk_d1 <= sclk_s[1];
            csn_d1 <= csn_s[1];
            fs_d1  <= fs_s[1];
            pwr_d1 <= pwr_s[1];
        end
    end

    logic sclk_rise, sclk_fall, cs_fall, cs_rise, fs_rise, pwr_fall, pwr_rise;
    assign sclk_rise = sclk_s[1] & ~sclk_d1;
    assign sclk_fall = ~sclk_s[1] & sclk_d1;
    assign cs_fall   = ~csn_s[1] & csn_d1;
    assign cs_rise   = csn_s[1] & ~csn_d1;
    assign fs_rise   = fs_s[1] & ~fs_d1;
    assign pwr_fall  = ~pwr_s[1] & pwr_d1;
    assign pwr_rise  = pwr_s[1] & ~pwr_d1;

    // ==========================================================
    // Power-down/reset pulse width measurement
    logic [12:0] low_cnt_q;
    logic        soft_rst;
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            low_cnt_q <= 13'h0;
        end else if (!pwr_s[1]) begin
            if (low_cnt_q != 13'h1fff) begin
                low_cnt_q <= low_cnt_q + 13'h1;
            end
        end else begin
            low_cnt_q <= 13'h0;
        end
    end

    // Widths between the reset and power-down windows act as a reset too
    assign soft_rst = pwr_rise && (32'(low_cnt_q) >= safc_pkg::RST_MIN_CYC)
                      && (32'(low_cnt_q) < safc_pkg::PWD_MIN_CYC);

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            powered_down_q <= 1'b0;
        end else if (!pwr_s[1] && 32'(low_cnt_q) >= safc_pkg::PWD_MIN_CYC) begin
            powered_down_q <= 1'b1;
        end else if (pwr_rise) begin
            powered_down_q <= 1'b0;
        end
    end

    logic dev_rst;
    assign dev_rst = soft_rst | !pwr_s[1];
    assign device_reset_pulse = soft_rst;

    // ==========================================================
    // Frame state
    typedef enum logic [1:0] {
        SAFC_IDLE    = 2'b00,
        SAFC_FRAME   = 2'b01,
        SAFC_CONVERT = 2'b10
    } safc_dstate_t;

    safc_dstate_t state_q;
    logic [4:0]   rise_cnt_q, fall_cnt_q;
    logic [8:0]   conv_cnt_q;
    logic         start_ev, abort_sample;
    logic [RB-1:0] shift_q, sample_q;

    // Start edge: frame sync rise in DSP, chip select fall in SPI
    assign start_ev = (mode == safc_pkg::SAFC_MODE_DSP) ? fs_rise : cs_fall;
    // Mid-sample abort after the 9th rise
    assign abort_sample = (state_q == SAFC_FRAME)
        && (32'(rise_cnt_q) >= safc_pkg::SAMPLE_EDGE)
        && ((mode == safc_pkg::SAFC_MODE_DSP) ? fs_rise : cs_rise);

    always_ff @(posedge core_clk) begin
        if (!rst_n || dev_rst || powered_down_q) begin
            state_q    <= SAFC_IDLE;
            rise_cnt_q <= 5'h0;
            fall_cnt_q <= 5'h0;
            conv_cnt_q <= 9'h0;
        end else begin
            case (state_q)
                SAFC_IDLE, SAFC_CONVERT: begin
                    if (start_ev) begin
                        // A start during conversion drops it
                        state_q    <= SAFC_FRAME;
                        rise_cnt_q <= 5'h0;
                        fall_cnt_q <= 5'h0;
                    end else if (state_q == SAFC_CONVERT) begin
                        if (32'(conv_cnt_q) >= safc_pkg::CONV_CYC - 1) begin
                            state_q <= SAFC_IDLE;
                        end
                        conv_cnt_q <= conv_cnt_q + 9'h1;
                    end
                end
                SAFC_FRAME: begin
                    if (abort_sample) begin
                        // DSP restarts at once; SPI waits for next fall
                        rise_cnt_q <= 5'h0;
                        fall_cnt_q <= 5'h0;
                        if (mode != safc_pkg::SAFC_MODE_DSP) begin
                            state_q <= SAFC_IDLE;
                        end
                    end else begin
                        if (sclk_rise && rise_cnt_q != 5'h1f) begin
                            rise_cnt_q <= rise_cnt_q + 5'h1;
                        end
                        if (sclk_fall) begin
                            fall_cnt_q <= fall_cnt_q + 5'h1;
                            if (32'(fall_cnt_q) == safc_pkg::FRAME_CLOCKS - 1) begin
                                state_q    <= SAFC_CONVERT;
                                conv_cnt_q <= 9'h0;
                            end
                        end
                    end
                end
                default: state_q <= SAFC_IDLE;
            endcase
        end
    end

    // Busy follows the converting state, three core cycles after the 16th fall
    assign link.busy = (state_q == SAFC_CONVERT);

    // ==========================================================
    // Sample capture on the 9th rise; result stored at conversion end
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            sample_q     <= '0;
            result_q     <= '0;
            result_valid <= 1'b0;
            sample_taken <= 1'b0;
        end else begin
            sample_taken <= 1'b0;
            result_valid <= 1'b0;
            if (state_q == SAFC_FRAME && sclk_rise
                && 32'(rise_cnt_q) == safc_pkg::SAMPLE_EDGE - 1) begin
                sample_q     <= sample_value;
                sample_taken <= 1'b1;
            end
            if (state_q == SAFC_CONVERT && !start_ev
                && 32'(conv_cnt_q) >= safc_pkg::CONV_CYC - 1) begin
                result_q     <= sample_q;
                result_valid <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Output shifter; the two-flop sync puts a bit three core cycles
    // after its link edge, so the sub-10 ns figures hold in core cycles
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            shift_q <= '0;
        end else if (start_ev) begin
            shift_q <= result_q;
        end else if (state_q == SAFC_FRAME && sclk_rise && !abort_sample) begin
            shift_q <= {shift_q[RB-2:0], 1'b0};
        end
    end

    // Driver enable: low with chip select high or reset pin low
    logic oe_q;
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            oe_q <= 1'b0;
        end else if (csn_s[1] || pwr_fall || !pwr_s[1] || powered_down_q) begin
            oe_q <= 1'b0;
        end else if (start_ev) begin
            oe_q <= 1'b1;
        end
    end

    assign link.serial_result_out = shift_q[RB-1];
    assign link.serial_result_oe  = oe_q;
endmodule // safc_device

//--- rtl/safc_host.sv
`timescale 1ns/1ns
// ==========================================================
// Host end: drives the frame and collects the serial result
module safc_host #(
    parameter int DIV_HALF = safc_pkg::HALF_CYC + 1
) (
    input  wire logic                            core_clk,
    input  wire logic                            rst_n,
    safc_link_if.host                            link,
    input  wire safc_pkg::safc_mode_t            mode,
    input  wire logic                            frame_req,
    input  wire logic                            abort_req,
    input  wire logic                            reset_req,
    input  wire logic                            powerdown_req,
    output logic                                 frame_ack,
    output logic [safc_pkg::RESULT_BITS-1:0]     data_q,
    output logic                                 data_valid,
    output logic                                 busy_seen
);
    localparam int RB = safc_pkg::RESULT_BITS;

    // Elaboration check; the 8-bit divider must reach setup plus one phase
    if (DIV_HALF < safc_pkg::HALF_CYC || DIV_HALF > 255 - safc_pkg::SETUP_CYC) begin : g_div_chk
        $error("DIV_HALF out of range");
    end

    // ==========================================================
    // Busy and data synchronisers
    logic [1:0] busy_s, sdo_s;
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            busy_s <= 2'h0;
            sdo_s  <= 2'h0;
        end else begin
            busy_s <= {busy_s[0], link.busy};
            sdo_s  <= {sdo_s[0], link.serial_result_line};
        end
    end
    assign busy_seen = busy_s[1];

    typedef enum logic [2:0] {
        SAFC_H_IDLE  = 3'b000,
        SAFC_H_SETUP = 3'b001,
        SAFC_H_CLK   = 3'b010,
        SAFC_H_HOLD  = 3'b011,
        SAFC_H_WAIT  = 3'b100,
        SAFC_H_PWR   = 3'b101
    } safc_hstate_t;

    safc_hstate_t st_q;
    logic [7:0]   div_q;
    logic [4:0]   edge_q;
    logic [12:0]  pw_q;
    logic         sclk_q, csn_q, fs_q, pwr_q;

    // Frame sequencer; clock is a divided core clock, never below 10 ns phase
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st_q <= SAFC_H_IDLE;
            div_q <= 8'h0;
            edge_q <= 5'h0;
            pw_q <= 13'h0;
            sclk_q <= 1'b1;
            csn_q <= 1'b1;
            fs_q <= 1'b0;
            pwr_q <= 1'b1;
            frame_ack <= 1'b0;
            data_valid <= 1'b0;
            data_q <= '0;
        end else begin
            frame_ack <= 1'b0;
            data_valid <= 1'b0;
            case (st_q)
                SAFC_H_IDLE: begin
                    div_q <= 8'h0;
                    if (reset_req || powerdown_req) begin
                        pwr_q <= 1'b0;
                        pw_q  <= powerdown_req ? 13'(safc_pkg::PWD_MIN_CYC + 1)
                                               : 13'(safc_pkg::RST_MIN_CYC + 1);
                        st_q  <= SAFC_H_PWR;
                    end else if (frame_req && !busy_s[1]) begin
                        // Wait out busy plus guard so no abort occurs
                        csn_q <= 1'b0;
                        st_q  <= SAFC_H_SETUP;
                        frame_ack <= 1'b1;
                    end
                end
                SAFC_H_SETUP: begin
                    div_q <= div_q + 8'h1;
                    if (32'(div_q) == safc_pkg::SETUP_CYC) begin
                        fs_q <= (mode == safc_pkg::SAFC_MODE_DSP);
                    end
                    if (32'(div_q) >= safc_pkg::SETUP_CYC + DIV_HALF) begin
                        fs_q <= 1'b0;
                        div_q <= 8'h0;
                        edge_q <= 5'h0;
                        st_q <= SAFC_H_CLK;
                    end
                end
                SAFC_H_CLK: begin
                    div_q <= div_q + 8'h1;
                    if (32'(div_q) >= DIV_HALF - 1) begin
                        div_q <= 8'h0;
                        sclk_q <= ~sclk_q;
                        if (sclk_q) begin
                            edge_q <= edge_q + 5'h1;
                            if (32'(edge_q) == safc_pkg::FRAME_CLOCKS - 1) begin
                                st_q <= SAFC_H_HOLD;
                            end
                        end else if (32'(edge_q) <= RB) begin
                            data_q <= {data_q[RB-2:0], sdo_s[1]};
                        end
                        if (abort_req && !sclk_q
                            && 32'(edge_q) >= safc_pkg::SAMPLE_EDGE) begin
                            csn_q <= 1'b1;
                            st_q <= SAFC_H_WAIT;
                        end
                    end
                end
                SAFC_H_HOLD: begin
                    div_q <= div_q + 8'h1;
                    if (32'(div_q) >= safc_pkg::HOLD_CYC) begin
                        csn_q <= 1'b1;
                        data_valid <= 1'b1;
                        div_q <= 8'h0;
                        st_q <= SAFC_H_WAIT;
                    end
                end
                SAFC_H_WAIT: begin
                    sclk_q <= 1'b1;
                    div_q <= div_q + 8'h1;
                    if (32'(div_q) >= safc_pkg::GUARD_CYC + 4) begin
                        st_q <= SAFC_H_IDLE;
                    end
                end
                SAFC_H_PWR: begin
                    pw_q <= pw_q - 13'h1;
                    if (pw_q == 13'h0) begin
                        pwr_q <= 1'b1;
                        st_q <= SAFC_H_IDLE;
                    end
                end
                default: st_q <= SAFC_H_IDLE;
            endcase
        end
    end

    assign link.serial_clk        = sclk_q;
    assign link.chip_select_n     = csn_q;
    assign link.frame_sync        = fs_q;
    assign link.powerdown_reset_n = pwr_q;
endmodule // safc_host

//--- dv/safc_link_properties.sv
`timescale 1ns/1ns
// ==========================================================
// Link checker: sees only the wires between host and device
module safc_link_properties (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic serial_clk,
    input wire logic chip_select_n,
    input wire logic frame_sync,
    input wire logic powerdown_reset_n,
    input wire logic busy,
    input wire logic serial_result_out,
    input wire logic serial_result_oe
);
    logic       sclk_p_q;
    logic [4:0] falls_q;
    logic [7:0] since16_q;
    logic [7:0] busy_cnt_q;
    logic       sclk_fell;
    logic       last_fall;

    // Falling link clock inside a frame; the 16th one starts conversion
    assign sclk_fell = sclk_p_q && !serial_clk;
    assign last_fall = sclk_fell && !chip_select_n && (falls_q == 5'd15);

    // Fall count, cleared between frames and on a frame-sync start
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            sclk_p_q <= 1'b1;
            falls_q  <= 5'd0;
        end else begin
            sclk_p_q <= serial_clk;
            if (chip_select_n || (frame_sync && !$past(frame_sync))) begin
                falls_q <= 5'd0;
            end else if (sclk_fell && falls_q != 5'd31) begin
                falls_q <= falls_q + 5'd1;
            end
        end
    end

    // Age of the last conversion start, saturating so it never wraps
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            since16_q <= 8'hff;
        end else if (last_fall) begin
            since16_q <= 8'h00;
        end else if (since16_q != 8'hff) begin
            since16_q <= since16_q + 8'h01;
        end
    end

    // Length of the present busy period
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            busy_cnt_q <= 8'h00;
        end else begin
            busy_cnt_q <= busy ? busy_cnt_q + 8'h01 : 8'h00;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    // ==========================================================
    // Conversion status
    sequence s_last_fall;
        last_fall;
    endsequence
    sequence s_busy_soon;
        ##[1:10] busy;
    endsequence

    a_busy_width_max: assert property (busy_cnt_q <= 8'(safc_pkg::CONV_CYC))
        else $error("busy held longer than one conversion");
    a_busy_on_time: assert property (s_last_fall |-> s_busy_soon)
        else $error("busy late after last clock fall");
    a_busy_has_cause: assert property ($rose(busy) |-> since16_q <= 8'd10)
        else $error("busy rose without a full frame");
    a_abort_busy: assert property (busy && ($fell(chip_select_n) || $rose(frame_sync)) |-> ##[1:8] !busy)
        else $error("start edge did not abort conversion");

    // ==========================================================
    // Data pin drive
    a_oe_off_cs: assert property ($rose(chip_select_n) |-> ##[1:4] !serial_result_oe)
        else $error("data pin still driven after deselect");
    a_oe_idle_off: assert property (chip_select_n [*5] |-> !serial_result_oe)
        else $error("data pin driven while deselected");
    a_oe_off_pwr: assert property ($fell(powerdown_reset_n) |-> ##[1:4] !serial_result_oe)
        else $error("data pin driven after reset pin fell");
    a_msb_dsp: assert property ($rose(frame_sync) |-> ##[1:4] serial_result_oe)
        else $error("first bit late after frame sync");
    a_msb_spi: assert property ($fell(chip_select_n) |-> ##[1:7] serial_result_oe)
        else $error("first bit late after select");
endmodule // safc_link_properties

//--- dv/sar_adc_serial_frame_control_tb.sv
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin \
    check_count++; \
    if ((got) !== (ex)) begin \
        n_mismatch++; \
        $display("BAD %s exp %0h got %0h", nm, ex, got); \
    end \
end
// ==========================================================
// Bench: host end and device end joined across one link
module sar_adc_serial_frame_control_tb;
    logic                             core_clk = 1'b0;
    logic                             rst_n = 1'b0;
    safc_pkg::safc_mode_t             mode = safc_pkg::SAFC_MODE_SPI;
    logic [safc_pkg::RESULT_BITS-1:0] sample_value = '0;
    logic                             frame_req = 1'b0;
    logic                             abort_req = 1'b0;
    logic                             reset_req = 1'b0;
    logic                             powerdown_req = 1'b0;
    logic                             sample_taken, result_valid, device_reset_pulse;
    logic                             powered_down_q, frame_ack, data_valid, busy_seen;
    logic [safc_pkg::RESULT_BITS-1:0] result_q, data_q, last_v;
    logic                             sclk_p = 1'b1;
    logic                             csn_p = 1'b1;
    logic [15:0]                      bits, got_bits;
    int n_ack = 0, n_rv = 0, n_dv = 0, n_st = 0, n_rp = 0, n_fall = 0, got_n = 0;
    int n_mismatch = 0;
    int check_count = 0;

    safc_link_if link_if ();
    safc_device safc_device_inst (.core_clk(core_clk), .rst_n(rst_n), .link(link_if),
        .mode(mode), .sample_value(sample_value), .sample_taken(sample_taken),
        .result_q(result_q), .result_valid(result_valid),
        .device_reset_pulse(device_reset_pulse), .powered_down_q(powered_down_q));
    safc_host safc_host_inst (.core_clk(core_clk), .rst_n(rst_n), .link(link_if),
        .mode(mode), .frame_req(frame_req), .abort_req(abort_req), .reset_req(reset_req),
        .powerdown_req(powerdown_req), .frame_ack(frame_ack), .data_q(data_q),
        .data_valid(data_valid), .busy_seen(busy_seen));
    safc_link_properties safc_link_properties_inst (.core_clk(core_clk), .rst_n(rst_n),
        .serial_clk(link_if.serial_clk), .chip_select_n(link_if.chip_select_n),
        .frame_sync(link_if.frame_sync), .powerdown_reset_n(link_if.powerdown_reset_n),
        .busy(link_if.busy), .serial_result_out(link_if.serial_result_out),
        .serial_result_oe(link_if.serial_result_oe));

    always #2 core_clk = ~core_clk;

    // Event counts and wire capture; tasks only read these, so no races
    always @(posedge core_clk) begin
        sclk_p <= link_if.serial_clk;
        csn_p <= link_if.chip_select_n;
        if (frame_ack === 1'b1) n_ack <= n_ack + 1;
        if (result_valid === 1'b1) n_rv <= n_rv + 1;
        if (data_valid === 1'b1) n_dv <= n_dv + 1;
        if (sample_taken === 1'b1) n_st <= n_st + 1;
        if (device_reset_pulse === 1'b1) n_rp <= n_rp + 1;
        if (sclk_p && !link_if.serial_clk && !link_if.chip_select_n) begin
            bits <= {bits[14:0], link_if.serial_result_line};
            n_fall <= n_fall + 1;
        end
        if (!csn_p && link_if.chip_select_n) begin
            got_bits <= bits;
            got_n <= n_fall;
            n_fall <= 0;
        end
    end

    // Bounded wait for a counter to move past its old value
    task automatic wait_more(ref int cnt, input int base);
        for (int i = 0; i < 800 && cnt == base; i++) @(posedge core_clk);
    endtask

    // Full frame; the wire carries the previous result, MSB first
    task automatic t_frame(input safc_pkg::safc_mode_t m, input logic [13:0] v, input bit chk);
        int b_ack, b_rv, b_dv, b_st;
        b_ack = n_ack;
        b_rv = n_rv;
        b_dv = n_dv;
        b_st = n_st;
        @(posedge core_clk);
        mode <= m;
        sample_value <= v;
        frame_req <= 1'b1;
        wait_more(n_ack, b_ack);
        frame_req <= 1'b0;
        wait_more(n_rv, b_rv);
        wait_more(n_dv, b_dv);
        repeat (8) @(posedge core_clk);
        `CHK("frames", b_ack + 1, n_ack)
        `CHK("samples", b_st + 1, n_st)
        `CHK("result_q", v, result_q)
        `CHK("sclk_falls", 16, got_n)
        `CHK("data_valid", b_dv + 1, n_dv)
        `CHK("busy_idle", 1'b0, busy_seen)
        if (chk) begin
            `CHK("data_q", last_v, data_q)
            `CHK("wire_bits", {last_v, 2'b00}, got_bits)
        end
        last_v = v;
        $display("frame test mode %0d done", m);
    endtask

    // Abort after the sampling edge: no conversion, old result kept
    task automatic t_abort();
        int b_ack, b_rv, b_st;
        b_ack = n_ack;
        b_rv = n_rv;
        b_st = n_st;
        @(posedge core_clk);
        mode <= safc_pkg::SAFC_MODE_SPI;
        sample_value <= ~last_v;
        frame_req <= 1'b1;
        wait_more(n_ack, b_ack);
        frame_req <= 1'b0;
        wait_more(n_st, b_st);
        abort_req <= 1'b1;
        for (int i = 0; i < 200 && link_if.chip_select_n !== 1'b1; i++) @(posedge core_clk);
        abort_req <= 1'b0;
        repeat (150) @(posedge core_clk);
        `CHK("abort_no_conv", b_rv, n_rv)
        `CHK("abort_result", last_v, result_q)
        $display("abort test done");
    endtask

    // Short low pulse on the reset pin: reset only
    task automatic t_reset();
        int b_rp;
        b_rp = n_rp;
        @(posedge core_clk);
        // One-cycle request: a held level would start a second pulse
        reset_req <= 1'b1;
        @(posedge core_clk);
        reset_req <= 1'b0;
        repeat (30) @(posedge core_clk);
        `CHK("reset_pulse", b_rp + 1, n_rp)
        `CHK("not_down", 1'b0, powered_down_q)
        $display("reset test done");
    endtask

    // Long low on the reset pin: power-down, data pin released
    task automatic t_pwdn();
        @(posedge core_clk);
        powerdown_req <= 1'b1;
        @(posedge core_clk);
        powerdown_req <= 1'b0;
        // Down state lasts only while the pin stays low
        for (int i = 0; i < 1900 && powered_down_q !== 1'b1; i++) @(posedge core_clk);
        `CHK("powered_down", 1'b1, powered_down_q)
        `CHK("oe_released", 1'b0, link_if.serial_result_oe)
        repeat (20) @(posedge core_clk);
        `CHK("powered_up", 1'b0, powered_down_q)
        $display("power-down test done");
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Watchdog: about three and a half times the expected run
    initial begin
        repeat (12000) @(posedge core_clk);
        n_mismatch++;
        $display("BAD watchdog exp done got hang");
        finish_test();
    end

    initial begin
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        t_frame(safc_pkg::SAFC_MODE_SPI, 14'h2a5c, 1'b0);
        t_frame(safc_pkg::SAFC_MODE_SPI, 14'h0000, 1'b1);
        t_frame(safc_pkg::SAFC_MODE_DSP, 14'h3fff, 1'b1);
        t_frame(safc_pkg::SAFC_MODE_DSP, 14'h1001, 1'b1);
        t_abort();
        t_frame(safc_pkg::SAFC_MODE_SPI, 14'h15a3, 1'b1);
        t_reset();
        t_pwdn();
        finish_test();
    end
endmodule // sar_adc_serial_frame_control_tb
